//--- src/ioc_clock_select.sv
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
// What this block does
// - enabled pll multiplies internal block by four
// - software pll enable at tuning bit 6
// - pll only with internal config and 8/4 MHz
// - pll enable forced zero where unavailable
// - trim adjusts fast oscillator only
// - five-bit signed trim in bits 4..0
// - tuning bit 5 reads zero
// - low source bit picks divided fast or RC
// - low source bit matters only at 31 kHz
// - source select switches after transition pause
// - source select cleared on reset
// - frequency select change acts immediately
// - frequency select resets to 1 MHz
// - slow RC always clocks watchdog and monitor
// - status flags show active clock source
// - at most one status flag set
// - idle bit picks idle or sleep
// - secondary select ignored unless enabled
// - frequency select encoding, 8 MHz to 31 kHz
// - source select encoding internal, secondary, primary
// - glitch-free switch: two old, three new edges
module ioc_clock_select (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // axi4-lite write
    input wire logic [ioc_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ioc_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // oscillator sources, asynchronous
    input wire logic primaryOscIn,
    input wire logic secondaryOscIn,
    input wire logic fastOscIn,
    input wire logic slowRcIn,
    input wire logic pllOscIn,
    input wire logic startupExpiredIn,
    input wire logic intOscStableIn,
    // configuration and cpu
    input wire logic [3:0] primaryOscConfig,
    input wire logic sleepReq,
    // outputs
    output logic [4:0] fastOscTrim,
    output logic pllActive,
    output logic [2:0] freqMultiplier,
    output logic devClkTick,
    output logic wdtClkTick,
    output logic enterIdle,
    output logic enterSleep
);
    localparam int NSYNC = 7;

    function automatic logic regHit(input logic [ioc_pkg::AXI_AW-1:0] a,
                                    input logic [ioc_pkg::AXI_AW-1:0] off);
        regHit = (a[ioc_pkg::AXI_AW-1:2] == off[ioc_pkg::AXI_AW-1:2]);
    endfunction

    function automatic logic [7:0] divMask(input logic [2:0] ifs);
        case (ifs)
            3'h7: divMask = 8'h00;
            3'h6: divMask = 8'h01;
            3'h5: divMask = 8'h03;
            3'h4: divMask = 8'h07;
            3'h3: divMask = 8'h0F;
            3'h2: divMask = 8'h1F;
            3'h1: divMask = 8'h3F;
            default: divMask = 8'hFF;
        endcase
    endfunction

    // input synchronisers: change accepted when stages two and three agree
    logic [NSYNC-1:0] asyncIn;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, lvl_q, edge_q;
    assign asyncIn = {intOscStableIn, startupExpiredIn, pllOscIn, slowRcIn,
                      fastOscIn, secondaryOscIn, primaryOscIn};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    lvl_q[gi] <= 1'b0;
                    edge_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= asyncIn[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        lvl_q[gi] <= s3_q[gi];
                    end
                    edge_q[gi] <= (s2_q[gi] == s3_q[gi]) && s3_q[gi] && !lvl_q[gi];
                end
            end
        end
    endgenerate
    logic priEdge, secEdge, fastEdge, slowEdge, pllEdge, ostLvl, stableLvl;
    assign priEdge = edge_q[0];
    assign secEdge = edge_q[1];
    assign fastEdge = edge_q[2];
    assign slowEdge = edge_q[3];
    assign pllEdge = edge_q[4];
    assign ostLvl = lvl_q[5];
    assign stableLvl = lvl_q[6];

    // registers
    ioc_pkg::ioc_tuning_s tun_q;
    ioc_pkg::ioc_control_s ctl_q;
    logic secOscEn_q;
    logic pllAvail;
    assign pllAvail = (primaryOscConfig == ioc_pkg::CFG_INTBLK_A) ||
                      (primaryOscConfig == ioc_pkg::CFG_INTBLK_B);

    // write channel: both address and data must be present, one at a time
    logic wrFire;
    assign awready = awvalid && wvalid && !bvalid;
    assign wready = awready;
    assign wrFire = awready;
    logic wrTun, wrCtl, wrTmr, wrMapped;
    assign wrTun = wrFire && wstrb[0] && regHit(awaddr, ioc_pkg::TUNING_OFF);
    assign wrCtl = wrFire && wstrb[0] && regHit(awaddr, ioc_pkg::CONTROL_OFF);
    assign wrTmr = wrFire && wstrb[0] && regHit(awaddr, ioc_pkg::TIMER_OFF);
    assign wrMapped = regHit(awaddr, ioc_pkg::TUNING_OFF) ||
                      regHit(awaddr, ioc_pkg::CONTROL_OFF) ||
                      regHit(awaddr, ioc_pkg::TIMER_OFF);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid <= 1'b0;
            bresp <= ioc_pkg::RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? ioc_pkg::RESP_OKAY : ioc_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tun_q <= '{lowSrc: 1'b0, pll_enable_bit: 1'b0, trim: ioc_pkg::TRIM_RESET};
        end else begin
            if (wrTun) begin
                tun_q.lowSrc <= wdata[ioc_pkg::TUN_LOWSRC_BIT];
                tun_q.pll_enable_bit <= wdata[ioc_pkg::TUN_PLL_BIT] && pllAvail;
                tun_q.trim <= wdata[ioc_pkg::TUN_TRIM_LSB +: 5];
            end else if (!pllAvail) begin
                tun_q.pll_enable_bit <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_q <= '{idle: 1'b0, ifs: ioc_pkg::IFS_RESET, scs: ioc_pkg::SCS_RESET};
        end else if (wrCtl) begin
            ctl_q.idle <= wdata[ioc_pkg::CTL_IDLE_BIT];
            ctl_q.ifs <= wdata[ioc_pkg::CTL_IFS_LSB +: 3];
            // secondary request dropped while its oscillator is off
            if (wdata[ioc_pkg::CTL_SCS_LSB +: 2] != ioc_pkg::SRC_SEC || secOscEn_q) begin
                ctl_q.scs <= wdata[ioc_pkg::CTL_SCS_LSB +: 2];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            secOscEn_q <= 1'b0;
        end else if (wrTmr) begin
            secOscEn_q <= wdata[ioc_pkg::TMR_SECEN_BIT];
        end
    end

    // trim goes to the fast oscillator only; slow RC has no trim input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fastOscTrim <= ioc_pkg::TRIM_RESET;
        end else begin
            fastOscTrim <= tun_q.trim;
        end
    end

    // pll gating
    logic pllOk;
    assign pllOk = tun_q.pll_enable_bit && pllAvail &&
                   (ctl_q.ifs == ioc_pkg::IFS_8MHZ || ctl_q.ifs == ioc_pkg::IFS_4MHZ);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pllActive <= 1'b0;
            freqMultiplier <= ioc_pkg::NO_MULT;
        end else begin
            pllActive <= pllOk;
            freqMultiplier <= pllOk ? ioc_pkg::PLL_FACTOR : ioc_pkg::NO_MULT;
        end
    end

    // internal block output: postscaler follows the select with no pause
    logic [7:0] postCnt_q;
    logic divHit, rcDirect, intTick;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            postCnt_q <= 8'h00;
        end else if (fastEdge) begin
            postCnt_q <= postCnt_q + 8'h01;
        end
    end
    assign divHit = (postCnt_q & divMask(ctl_q.ifs)) == divMask(ctl_q.ifs);
    assign rcDirect = (ctl_q.ifs == ioc_pkg::IFS_31KHZ) && !tun_q.lowSrc;
    // pll output replaces the internal tap; it is x4 of the selected tap
    assign intTick = pllActive ? pllEdge :
                     rcDirect ? slowEdge : (fastEdge && divHit);

    // watchdog and monitor stay on the slow RC whatever the selection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdtClkTick <= 1'b0;
        end else begin
            wdtClkTick <= slowEdge;
        end
    end

    // source switch with pause
    logic [2:0] srcTick;
    assign srcTick = {intTick, secEdge, priEdge};
    logic [1:0] target, active_q, pend_q, cnt_q;
    ioc_pkg::ioc_switch_e sw_q;
    assign target = ctl_q.scs[1] ? ioc_pkg::SRC_INT :
                    (ctl_q.scs[0] ? ioc_pkg::SRC_SEC : ioc_pkg::SRC_PRI);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_q <= ioc_pkg::SW_RUN;
            active_q <= ioc_pkg::SRC_PRI;
            pend_q <= ioc_pkg::SRC_PRI;
            cnt_q <= 2'h0;
        end else begin
            case (sw_q)
                ioc_pkg::SW_RUN: begin
                    if (target != active_q) begin
                        sw_q <= ioc_pkg::SW_OLD;
                        pend_q <= target;
                        cnt_q <= 2'h0;
                    end
                end
                ioc_pkg::SW_OLD: begin
                    if (srcTick[active_q]) begin
                        if (cnt_q == ioc_pkg::OLD_EDGES - 2'h1) begin
                            sw_q <= ioc_pkg::SW_NEW;
                            cnt_q <= 2'h0;
                        end else begin
                            cnt_q <= cnt_q + 2'h1;
                        end
                    end
                end
                ioc_pkg::SW_NEW: begin
                    if (srcTick[pend_q]) begin
                        if (cnt_q == ioc_pkg::NEW_EDGES - 2'h1) begin
                            sw_q <= ioc_pkg::SW_RUN;
                            active_q <= pend_q;
                            cnt_q <= 2'h0;
                        end else begin
                            cnt_q <= cnt_q + 2'h1;
                        end
                    end
                end
                default: sw_q <= ioc_pkg::SW_RUN;
            endcase
        end
    end

    // device clock is held off for the whole pause
    logic running;
    assign running = (sw_q == ioc_pkg::SW_RUN);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            devClkTick <= 1'b0;
        end else begin
            devClkTick <= running && srcTick[active_q];
        end
    end

    // status flags, at most one set by construction
    logic priRdy, intRdy, secRun;
    assign priRdy = running && active_q == ioc_pkg::SRC_PRI && ostLvl;
    assign intRdy = running && active_q == ioc_pkg::SRC_INT && stableLvl && !rcDirect;
    assign secRun = running && active_q == ioc_pkg::SRC_SEC;

    // sleep request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enterIdle <= 1'b0;
            enterSleep <= 1'b0;
        end else begin
            enterIdle <= sleepReq && ctl_q.idle;
            enterSleep <= sleepReq && !ctl_q.idle;
        end
    end

    // read channel: one outstanding read, answer one cycle after acceptance
    logic rdFire;
    logic [7:0] rdByte;
    assign arready = !rvalid;
    assign rdFire = arvalid && arready;
    always_comb begin
        rdByte = 8'h00;
        if (regHit(araddr, ioc_pkg::TUNING_OFF)) begin
            rdByte = {tun_q.lowSrc, tun_q.pll_enable_bit && pllAvail, 1'b0, tun_q.trim};
        end else if (regHit(araddr, ioc_pkg::CONTROL_OFF)) begin
            rdByte = {ctl_q.idle, ctl_q.ifs, priRdy, intRdy, ctl_q.scs};
        end else if (regHit(araddr, ioc_pkg::TIMER_OFF)) begin
            rdByte[ioc_pkg::TMR_SECRUN_BIT] = secRun;
            rdByte[ioc_pkg::TMR_SECEN_BIT] = secOscEn_q;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= ioc_pkg::RESP_OKAY;
        end else if (rdFire) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rdByte};
            rresp <= (regHit(araddr, ioc_pkg::TUNING_OFF) ||
                      regHit(araddr, ioc_pkg::CONTROL_OFF) ||
                      regHit(araddr, ioc_pkg::TIMER_OFF)) ?
                     ioc_pkg::RESP_OKAY : ioc_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // checks
    property p_pll_gate;
        @(posedge clk) disable iff (!reset_n)
        pllActive |-> $past(tun_q.pll_enable_bit && pllAvail && ctl_q.ifs[2:1] == 2'b11);
    endproperty
    a_pll_gate: assert property (p_pll_gate) else $error("pll active without its conditions");

    property p_tun_read;
        @(posedge clk) disable iff (!reset_n)
        (rdFire && regHit(araddr, ioc_pkg::TUNING_OFF) && !pllAvail)
            |=> rvalid && rdata[6:5] == 2'b00;
    endproperty
    a_tun_read: assert property (p_tun_read) else $error("tuning bits 6:5 not zero");

    property p_sec_ignored;
        @(posedge clk) disable iff (!reset_n)
        (wrCtl && !secOscEn_q && wdata[1:0] == 2'b01) |=> $stable(ctl_q.scs);
    endproperty
    a_sec_ignored: assert property (p_sec_ignored) else $error("secondary taken while off");

    property p_reset_vals;
        @(posedge clk) $rose(reset_n) |-> ctl_q.scs == 2'b00 && ctl_q.ifs == 3'b100;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

    property p_onehot_flags;
        @(posedge clk) disable iff (!reset_n)
        $onehot0({priRdy, intRdy, secRun});
    endproperty
    a_onehot_flags: assert property (p_onehot_flags) else $error("two source flags set");

    property p_switch_start;
        @(posedge clk) disable iff (!reset_n)
        (running && target != active_q) |=> sw_q == ioc_pkg::SW_OLD ##1 !devClkTick;
    endproperty
    a_switch_start: assert property (p_switch_start) else $error("switch did not pause");

    property p_wdt_rc;
        @(posedge clk) disable iff (!reset_n)
        slowEdge |=> wdtClkTick;
    endproperty
    a_wdt_rc: assert property (p_wdt_rc) else $error("watchdog tick lost");

    property p_low_src;
        @(posedge clk) disable iff (!reset_n)
        (!pllActive && ctl_q.ifs != 3'b000) |-> intTick == (fastEdge && divHit);
    endproperty
    a_low_src: assert property (p_low_src) else $error("low source leaked");
endmodule

//--- src/ioc_pkg.sv
package ioc_pkg;
    localparam int AXI_AW = 4;
    // register byte offsets
    localparam logic [AXI_AW-1:0] TUNING_OFF = 4'h0;
    localparam logic [AXI_AW-1:0] CONTROL_OFF = 4'h4;
    localparam logic [AXI_AW-1:0] TIMER_OFF = 4'h8;
    // tuning register fields
    localparam int TUN_TRIM_LSB = 0;
    localparam int TUN_UNUSED_BIT = 5;
    localparam int TUN_PLL_BIT = 6;
    localparam int TUN_LOWSRC_BIT = 7;
    // control register fields
    localparam int CTL_SCS_LSB = 0;
    localparam int CTL_INTRDY_BIT = 2;
    localparam int CTL_PRIRDY_BIT = 3;
    localparam int CTL_IFS_LSB = 4;
    localparam int CTL_IDLE_BIT = 7;
    // timer control fields
    localparam int TMR_SECEN_BIT = 3;
    localparam int TMR_SECRUN_BIT = 6;
    // reset values
    localparam logic [4:0] TRIM_RESET = 5'h00;
    localparam logic [2:0] IFS_RESET = 3'h4;
    localparam logic [1:0] SCS_RESET = 2'h0;
    // encodings
    localparam logic [3:0] CFG_INTBLK_A = 4'h9;
    localparam logic [3:0] CFG_INTBLK_B = 4'h8;
    localparam logic [2:0] IFS_8MHZ = 3'h7;
    localparam logic [2:0] IFS_4MHZ = 3'h6;
    localparam logic [2:0] IFS_31KHZ = 3'h0;
    localparam logic [1:0] SRC_PRI = 2'h0;
    localparam logic [1:0] SRC_SEC = 2'h1;
    localparam logic [1:0] SRC_INT = 2'h2;
    localparam logic [2:0] PLL_FACTOR = 3'h4;
    localparam logic [2:0] NO_MULT = 3'h1;
    // clock switch pause, in source edges
    localparam logic [1:0] OLD_EDGES = 2'h2;
    localparam logic [1:0] NEW_EDGES = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SW_RUN = 3'b001,
        SW_OLD = 3'b010,
        SW_NEW = 3'b100
    } ioc_switch_e;

    typedef struct packed {
        logic lowSrc;
        logic pll_enable_bit;
        logic [4:0] trim;
    } ioc_tuning_s;

    typedef struct packed {
        logic idle;
        logic [2:0] ifs;
        logic [1:0] scs;
    } ioc_control_s;
endpackage

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam logic [3:0] TUN = ioc_pkg::TUNING_OFF;
    localparam logic [3:0] CTL = ioc_pkg::CONTROL_OFF;
    localparam logic [3:0] TMR = ioc_pkg::TIMER_OFF;
    localparam logic [1:0] OK = ioc_pkg::RESP_OKAY;
    logic clk, reset_n;
    logic [3:0] awaddr, araddr, wstrb, oscConfig;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic primaryOsc, secondaryOsc, fastOsc, slowRc, pllOsc;
    logic startupExpired, intOscStable, sleepReq;
    logic [4:0] fastOscTrim;
    logic [2:0] freqMultiplier;
    logic pllActive, devClkTick, wdtClkTick, enterIdle, enterSleep;
    int fails, cmp_count, cycles, phase;
    logic [2:0] ifsTab [5] = '{3'h7, 3'h5, 3'h1, 3'h0, 3'h0};
    logic srcTab [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    // 512 cycles: fast osc edge every 4, slow rc every 6
    int expTab [5] = '{128, 32, 2, 85, 0};

    ioc_clock_select DUT (.clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .primaryOscIn(primaryOsc), .secondaryOscIn(secondaryOsc), .fastOscIn(fastOsc),
        .slowRcIn(slowRc), .pllOscIn(pllOsc), .startupExpiredIn(startupExpired),
        .intOscStableIn(intOscStable), .primaryOscConfig(oscConfig), .sleepReq(sleepReq),
        .fastOscTrim(fastOscTrim), .pllActive(pllActive), .freqMultiplier(freqMultiplier),
        .devClkTick(devClkTick), .wdtClkTick(wdtClkTick), .enterIdle(enterIdle),
        .enterSleep(enterSleep));

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    // sources held at least two clocks per level
    always @(posedge clk) begin
        phase <= phase + 1;
        fastOsc <= phase[1];
        pllOsc <= phase[1];
        primaryOsc <= phase[2];
        secondaryOsc <= phase[3];
        slowRc <= (phase % 6) < 3;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end

    task results();
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chkData(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: data %h exp %h", $time, got, exp);
        end
    endtask

    task chkResp(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: resp %b exp %b", $time, got, exp);
        end
    endtask

    task chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %b exp %b", $time, got, exp);
        end
    endtask

    task chkNear(input int got, input int exp, input int tol);
        cmp_count++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("unexpected at %0t: count %0d exp %0d", $time, got, exp);
        end
    endtask

    // handshakes judged at the rising edge; each channel released once taken
    task wr(input logic [3:0] a, input logic [7:0] d);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (!awDone && awready === 1'b1) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        chkResp(bresp, OK);
        bready <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task rdChk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chkData(d & {24'hFFFFFF, m}, {24'h000000, e & m});
        chkResp(r, er);
    endtask

    // status bits settle after synchronisers and switch pauses
    task pollBit(input logic [3:0] a, input int b, input logic v);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        rd(a, d, r);
        while (d[b] !== v && n < 60) begin
            rd(a, d, r);
            n++;
        end
        chk1(d[b], v);
    endtask

    task count(input int n, output int dev, output int wdt, output int idl, output int slp);
        dev = 0;
        wdt = 0;
        idl = 0;
        slp = 0;
        repeat (n) begin
            @(negedge clk);
            dev += (devClkTick === 1'b1);
            wdt += (wdtClkTick === 1'b1);
            idl += (enterIdle === 1'b1);
            slp += (enterSleep === 1'b1);
        end
    endtask

    initial begin
        int dv, wd, il, sl;
        {awaddr, araddr, wstrb, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        {phase, cycles, fails, cmp_count, sleepReq, startupExpired} = '0;
        intOscStable = 1'b1;
        oscConfig = ioc_pkg::CFG_INTBLK_A;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rdChk(TUN, 8'h00, 8'hFF, OK);
        rdChk(CTL, 8'h40, 8'hFF, OK);
        rdChk(TMR, 8'h00, 8'hFF, OK);
        rdChk(4'hC, 8'h00, 8'hFF, ioc_pkg::RESP_SLVERR);
        wr(TUN, 8'hFF);
        rdChk(TUN, 8'hDF, 8'hFF, OK);
        chkData({27'h0, fastOscTrim}, 32'h1F);
        wr(TUN, 8'h10);
        @(negedge clk);
        chkData({27'h0, fastOscTrim}, 32'h10);
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            oscConfig <= c ? ioc_pkg::CFG_INTBLK_B : ioc_pkg::CFG_INTBLK_A;
            wr(TUN, 8'h40);
            for (int i = 0; i < 8; i++) begin
                wr(CTL, 8'(i << 4));
                repeat (3) @(posedge clk);
                chk1(pllActive, i >= 6);
                chkData({29'h0, freqMultiplier}, i >= 6 ? 32'h4 : 32'h1);
            end
        end
        @(posedge clk);
        oscConfig <= 4'h2;
        repeat (4) @(posedge clk);
        rdChk(TUN, 8'h00, 8'hFF, OK);
        chk1(pllActive, 1'b0);
        @(posedge clk);
        oscConfig <= ioc_pkg::CFG_INTBLK_A;
        rdChk(TUN, 8'h00, 8'hFF, OK);
        @(posedge clk);
        startupExpired <= 1'b1;
        pollBit(CTL, 3, 1'b1);
        wr(CTL, 8'h71);
        rdChk(CTL, 8'h70, 8'hF3, OK);
        rdChk(TMR, 8'h00, 8'hFF, OK);
        wr(TMR, 8'h08);
        wr(CTL, 8'h71);
        repeat (2) @(posedge clk);
        count(8, dv, wd, il, sl);
        chkNear(dv, 0, 0);
        chk1(devClkTick, 1'b0);
        pollBit(TMR, 6, 1'b1);
        rdChk(CTL, 8'h71, 8'hFF, OK);
        wr(CTL, 8'h73);
        pollBit(CTL, 2, 1'b1);
        rdChk(CTL, 8'h77, 8'hFF, OK);
        rdChk(TMR, 8'h08, 8'hFF, OK);
        intOscStable <= 1'b0;
        pollBit(CTL, 2, 1'b0);
        rdChk(CTL, 8'h73, 8'hFF, OK);
        intOscStable <= 1'b1;
        pollBit(CTL, 2, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wr(TUN, {srcTab[i], 7'h00});
            wr(CTL, {1'b0, ifsTab[i], 4'h3});
            count(512, dv, wd, il, sl);
            chkNear(dv, expTab[i], 1);
            chkNear(wd, 85, 1);
        end
        for (int i = 0; i < 2; i++) begin
            wr(CTL, {i[0], 7'h73});
            @(posedge clk);
            sleepReq <= 1'b1;
            @(posedge clk);
            sleepReq <= 1'b0;
            count(3, dv, wd, il, sl);
            chkNear(il, i, 0);
            chkNear(sl, 1 - i, 0);
        end
        wr(CTL, 8'h70);
        pollBit(CTL, 3, 1'b1);
        rdChk(CTL, 8'h78, 8'hFF, OK);
        wr(CTL, 8'h22);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rdChk(CTL, 8'h40, 8'hF3, OK);
        rdChk(TUN, 8'h00, 8'hFF, OK);
        pollBit(CTL, 3, 1'b1);
        results();
    end
endmodule
